/* hdl/ext_clock_trigger_control.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module pin_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  import ext_clock_trigger_pkg::*;

  logic [SYNC_STAGES-1:0] s_r;
  logic [SYNC_STAGES-1:0] s_nxt;
  logic                   level_nxt;
  logic                   rise_nxt;

  // A change counts only once stages two and three agree.
  always_comb begin
    s_nxt     = {s_r[1:0], pin};
    level_nxt = level;
    rise_nxt  = 1'b0;
    if (s_r[1] == s_r[2]) begin
      level_nxt = s_r[2];
      rise_nxt  = s_r[2] & ~level;
    end
  end

  // Registers the chain and the filtered level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r   <= SYNC_RESET;
      level <= 1'b0;
      rise  <= 1'b0;
    end else if (ce) begin
      s_r   <= s_nxt;
      level <= level_nxt;
      rise  <= rise_nxt;
    end
  end
endmodule

// ----------------------------------------
// Pacing sequencer for one direction
// ----------------------------------------
module pace_seq (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          ce,
  input  wire ext_clock_trigger_pkg::cfg_t   cfg,
  input  wire logic                          start,
  input  wire logic                          stop,
  input  wire logic                          ext_rise,
  input  wire logic                          trig_lvl,
  output ext_clock_trigger_pkg::status_t     status
);
  import ext_clock_trigger_pkg::*;

  seq_state_t            state_r;
  seq_state_t            state_nxt;
  logic [CHAN_W-1:0]     chan_r;
  logic [CHAN_W-1:0]     chan_nxt;
  logic [INTERVAL_W-1:0] timer_r;
  logic [INTERVAL_W-1:0] timer_nxt;
  logic [COUNT_W-1:0]    cnt_r;
  logic [COUNT_W-1:0]    cnt_nxt;
  logic                  pend_r;
  logic                  pend_nxt;
  status_t               status_nxt;
  logic                  fire;
  logic                  gated;
  logic                  at_bound;
  logic                  last_hit;
  logic [CHAN_W-1:0]     chan_next;

  // Decodes the pacing source and the stop boundary.
  always_comb begin
    gated    = cfg.hw_trigger_mode == TRIG_GATED;
    at_bound = !cfg.list_clocking_select || chan_r == '0;
    if (!cfg.ext_clock) begin
      fire = timer_r == '0;
    end else if (cfg.list_clocking_select && chan_r != '0) begin
      fire = timer_r == '0;
    end else begin
      fire = ext_rise;
    end
    last_hit  = cfg.count_limit != '0 && (cnt_r + COUNT_W'(1)) == cfg.count_limit;
    chan_next = (chan_r == cfg.chan_last) ? '0 : chan_r + CHAN_W'(1);
  end

  // Next state of the sequencer.
  always_comb begin
    state_nxt  = state_r;
    chan_nxt   = chan_r;
    timer_nxt  = (timer_r == '0) ? '0 : timer_r - INTERVAL_W'(1);
    cnt_nxt    = cnt_r;
    pend_nxt   = pend_r;
    status_nxt = '0;
    status_nxt.channel = status.channel;
    unique case (state_r)
      ST_IDLE: begin
        if (start && !stop) begin
          chan_nxt  = '0;
          timer_nxt = '0;
          cnt_nxt   = '0;
          pend_nxt  = 1'b1;
          // Triggered modes wait for the line first.
          state_nxt = (cfg.hw_trigger_mode == TRIG_OFF) ? ST_RUN : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (stop) begin
          state_nxt = ST_IDLE;
        end else if (trig_lvl) begin
          state_nxt = ST_RUN;
          timer_nxt = '0;
          pend_nxt  = 1'b1;
        end
      end
      ST_RUN: begin
        if (stop) begin
          state_nxt = ST_IDLE;
        end else if (fire) begin
          status_nxt.event_pulse = 1'b1;
          status_nxt.channel     = chan_r;
          chan_nxt  = chan_next;
          timer_nxt = cfg.interval - INTERVAL_W'(1);
          cnt_nxt   = cnt_r + COUNT_W'(1);
          pend_nxt  = 1'b0;
          if (last_hit) begin
            state_nxt       = ST_IDLE;
            status_nxt.done = 1'b1;
          end
        end else if (gated && !trig_lvl && !pend_r && at_bound) begin
          // A short pulse still yields its first event before stopping.
          state_nxt = ST_WAIT;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    status_nxt.busy = state_nxt != ST_IDLE;
  end

  // Registers the sequencer and its status.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      chan_r  <= '0;
      timer_r <= '0;
      cnt_r   <= '0;
      pend_r  <= 1'b0;
      status  <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      chan_r  <= chan_nxt;
      timer_r <= timer_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
      status  <= status_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [INTERVAL_W:0] gap_r;
  logic                seen_r;
  logic [CHAN_W-1:0]   lch_r;

  // Tracks spacing and order of events within one run.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_r  <= '0;
      seen_r <= 1'b0;
      lch_r  <= '0;
    end else if (ce) begin
      gap_r <= status.event_pulse ? (INTERVAL_W+1)'(1) : gap_r + (INTERVAL_W+1)'(1);
      if (status.event_pulse) begin
        lch_r <= status.channel;
      end
      seen_r <= (state_r == ST_RUN) && (seen_r || status.event_pulse);
    end
  end

  sequence trig_seen_s;
    state_r == ST_WAIT && trig_lvl && !stop && !cfg.ext_clock;
  endsequence

  sequence first_event_s;
    ##2 status.event_pulse;
  endsequence

  AST_EXT_EDGE_FIRES: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_RUN && !stop && cfg.ext_clock && ext_rise && (!cfg.list_clocking_select || chan_r == '0)
    |=> status.event_pulse && status.channel == $past(chan_r))
    else $error("external clock edge did not start an event");

  AST_LIST_START_ON_EDGE: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    status.event_pulse && cfg.ext_clock && (status.channel == '0 || !cfg.list_clocking_select)
    |-> $past(ext_rise))
    else $error("list start without an external clock edge");

  AST_OFF_NEVER_WAITS: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_IDLE && start && !stop && cfg.hw_trigger_mode == TRIG_OFF |=> state_r == ST_RUN)
    else $error("trigger off mode did not start at once");

  AST_WAIT_HOLDS: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_WAIT && !trig_lvl |=> !status.event_pulse && state_r != ST_RUN)
    else $error("sequencer ran before trigger went high");

  AST_FIRST_ALIGNED: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    trig_seen_s |-> first_event_s)
    else $error("first event not aligned to trigger edge");

  AST_INTERVAL_EXACT: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    status.event_pulse && seen_r && !cfg.ext_clock |-> gap_r == {1'b0, cfg.interval})
    else $error("event spacing differs from the interval");

  AST_SHORT_PULSE_ONE: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_RUN && pend_r && !stop |=> state_r != ST_WAIT)
    else $error("gated stop before the first event");

  AST_GATED_BOUNDARY: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_RUN ##1 state_r == ST_WAIT |-> !cfg.list_clocking_select || chan_r == '0)
    else $error("gated stop inside a channel list");

  AST_GATED_STOPS: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_RUN && !stop && !fire && gated && !trig_lvl && !pend_r && at_bound
    |=> state_r == ST_WAIT ##1 !status.event_pulse)
    else $error("gated mode kept running with trigger low");

  AST_COUNT_END: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    state_r == ST_RUN && !stop && fire && last_hit |=> state_r == ST_IDLE && status.done)
    else $error("count reached but sequencer kept running");

  AST_CHANNEL_WRAP: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    status.event_pulse && seen_r |-> status.channel == ((lch_r == cfg.chan_last) ? '0 : lch_r + CHAN_W'(1)))
    else $error("channel order broken");
endmodule

// ----------------------------------------
// Top level
// ----------------------------------------
// Function
// - Output clock rising edge paces output updates.
// - First output clock pulse is acted upon.
// - Whole-list or per-channel clocking; whole-list default.
// - Input trigger single-shot, gated or off.
// - Single-shot input waits high, runs to stop/count.
// - First sample on trigger; then exact interval.
// - Gated input samples while trigger high.
// - Gated pulse under 250ns gives one conversion; code gives one (whole list if list-clocked), more while trigger high.
// - Gated input stops at list or channel end.
// - Gated restart aligns to next trigger edge.
// - Output trigger single-shot, gated or off.
// - Single-shot output waits high, runs to stop/count.
// - First update on trigger; then exact interval.
// - Gated output updates while trigger high.
// - Gated pulse under 250ns gives one update; code gives one (whole list if list-clocked), more while trigger high.
// - Gated output stops at list end or channel.
// - Triggered external clock starts at next edge.
// - Conversion within 200ns, slewing within 30ns.
// - Per-channel clocking converts next channel, wrapping.
module ext_clock_trigger_control (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          ce,
  input  wire logic                          in_clk_pin,
  input  wire logic                          in_trig_pin,
  input  wire logic                          out_clk_pin,
  input  wire logic                          out_trig_pin,
  input  wire ext_clock_trigger_pkg::cfg_t   in_cfg,
  input  wire ext_clock_trigger_pkg::cfg_t   out_cfg,
  input  wire logic                          in_start,
  input  wire logic                          in_stop,
  input  wire logic                          out_start,
  input  wire logic                          out_stop,
  output ext_clock_trigger_pkg::status_t     in_status,
  output ext_clock_trigger_pkg::status_t     out_status
);
  import ext_clock_trigger_pkg::*;

  logic [3:0] pin_vec;
  logic [3:0] lvl_vec;
  logic [3:0] rise_vec;

  // Gathers the four outside pins for the synchronisers.
  assign pin_vec = {out_trig_pin, out_clk_pin, in_trig_pin, in_clk_pin};

  // One synchroniser per pin.
  for (genvar i = 0; i < 4; i++) begin : g_sync
    pin_sync u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .pin     (pin_vec[i]),
      .level   (lvl_vec[i]),
      .rise    (rise_vec[i])
    );
  end

  // Input sampling sequencer.
  pace_seq u_in_seq (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .cfg      (in_cfg),
    .start    (in_start),
    .stop     (in_stop),
    .ext_rise (rise_vec[0]),
    .trig_lvl (lvl_vec[1]),
    .status   (in_status)
  );

  // Output update sequencer.
  pace_seq u_out_seq (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .cfg      (out_cfg),
    .start    (out_start),
    .stop     (out_stop),
    .ext_rise (rise_vec[2]),
    .trig_lvl (lvl_vec[3]),
    .status   (out_status)
  );
endmodule
`default_nettype wire

/* hdl/ext_clock_trigger_pkg.sv */
`default_nettype none
package ext_clock_trigger_pkg;
  // ----------------------------------------
  // Timing figures and their cycle counts
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SYNC_DELAY_NS = 200;
  localparam int TRIGGER_MIN_HIGH_NS = 60;
  localparam int TRIGGER_SINGLE_MAX_HIGH_NS = 250;
  localparam int TRIGGER_TO_CLOCK_LEAD_NS = 50;
  localparam int OUTSIDE_CLOCK_PHASE_MIN_NS = 25;
  localparam int INPUT_HOLD_LATENCY_NS = 200;
  localparam int OUTPUT_SLEW_LATENCY_NS = 30;
  // Longest times round down, least times round up.
  localparam int SYNC_DELAY_CYC = SYNC_DELAY_NS / CLK_PERIOD_NS;
  localparam int TRIGGER_MIN_HIGH_CYC = (TRIGGER_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIGGER_SINGLE_MAX_HIGH_CYC = TRIGGER_SINGLE_MAX_HIGH_NS / CLK_PERIOD_NS;
  localparam int TRIGGER_TO_CLOCK_LEAD_CYC = (TRIGGER_TO_CLOCK_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUTSIDE_CLOCK_PHASE_MIN_CYC = (OUTSIDE_CLOCK_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INPUT_HOLD_LATENCY_CYC = INPUT_HOLD_LATENCY_NS / CLK_PERIOD_NS;
  localparam int OUTPUT_SLEW_LATENCY_CYC = OUTPUT_SLEW_LATENCY_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int SYNC_STAGES = 3;
  localparam int INTERVAL_W = 16;
  localparam int CHAN_W = 4;
  localparam int COUNT_W = 16;
  localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TRIG_OFF         = 2'h0,
    TRIG_SINGLE_SHOT = 2'h1,
    TRIG_GATED       = 2'h2
  } hw_trigger_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN  = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic                   ext_clock;
    logic                   list_clocking_select;
    hw_trigger_mode_t       hw_trigger_mode;
    logic [INTERVAL_W-1:0]  interval;
    logic [CHAN_W-1:0]      chan_last;
    logic [COUNT_W-1:0]     count_limit;
  } cfg_t;

  typedef struct packed {
    logic               event_pulse;
    logic [CHAN_W-1:0]  channel;
    logic               busy;
    logic               done;
  } status_t;
endpackage
`default_nettype wire

/* testbench/ext_source.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// External clock and trigger source
// ----------------------------------------
module ext_source (
  output var logic clk_pin,
  output var logic trig_pin
);
  // Both lines rest low; the clock stands still between bursts.
  initial begin
    clk_pin = 1'b0;
    trig_pin = 1'b0;
  end

  // Runs n periods of 160 ns, offset so that no pin edge meets a sampling edge.
  task automatic clocks(input int n);
    #3;
    repeat (n) begin
      clk_pin = 1'b1;
      #80;
      clk_pin = 1'b0;
      #80;
    end
  endtask

  // Holds the trigger high for the given time.
  task automatic pulse(input int ns);
    #3;
    trig_pin = 1'b1;
    #(ns);
    trig_pin = 1'b0;
  endtask

  // Raises the trigger ahead of the first clock edge, then clocks.
  task automatic lead_clocks(input int n);
    trig_pin = 1'b1;
    #60;
    clocks(n);
    trig_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/ext_clock_trigger_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module ext_clock_trigger_control_bench;
  import ext_clock_trigger_pkg::*;

  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              ce = 1'b1;
  wire logic         in_clk_pin, in_trig_pin, out_clk_pin, out_trig_pin;
  cfg_t              cfg [2];
  logic              start [2];
  logic              stop [2];
  status_t           st [2];
  int                cyc = 0;
  int                err_total = 0;
  int                num_checks = 0;
  int                ev_t [2][$];
  logic [CHAN_W-1:0] ev_c [2][$];
  int                t0;
  int                n;
  int                done_t [2];

  // ----------------------------------------
  // Clock, sources and device
  // ----------------------------------------
  // The clock toggles every half period of 2 ns.
  always #2 clk = ~clk;

  ext_source src_in (.clk_pin(in_clk_pin), .trig_pin(in_trig_pin));
  ext_source src_out (.clk_pin(out_clk_pin), .trig_pin(out_trig_pin));

  ext_clock_trigger_control uut (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .in_clk_pin(in_clk_pin), .in_trig_pin(in_trig_pin),
    .out_clk_pin(out_clk_pin), .out_trig_pin(out_trig_pin),
    .in_cfg(cfg[0]), .out_cfg(cfg[1]),
    .in_start(start[0]), .in_stop(stop[0]),
    .out_start(start[1]), .out_stop(stop[1]),
    .in_status(st[0]), .out_status(st[1])
  );

  // Logs each event with its cycle and channel, and cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    for (int d = 0; d < 2; d++) begin
      if (st[d].event_pulse === 1'b1) begin
        ev_t[d].push_back(cyc);
        ev_c[d].push_back(st[d].channel);
      end
      if (st[d].done === 1'b1) begin
        done_t[d] = cyc;
      end
    end
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic cfg_t mk(input logic x, input logic l, input hw_trigger_mode_t m,
                              input int iv, input int cl, input int cnt);
    return '{x, l, m, 16'(iv), 4'(cl), 16'(cnt)};
  endfunction

  // Loads a setting and arms one direction with a one-cycle start.
  task automatic go(input int d, input cfg_t c);
    ev_t[d].delete();
    ev_c[d].delete();
    cfg[d] = c;
    start[d] = 1'b1;
    @(negedge clk);
    start[d] = 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Stops one direction and checks that it has gone idle.
  task automatic halt(input int d);
    stop[d] = 1'b1;
    @(negedge clk);
    stop[d] = 1'b0;
    @(negedge clk);
    chk("busy after stop", 0, st[d].busy);
  endtask

  task automatic clocks(input int d, input int k);
    if (d == 0) src_in.clocks(k); else src_out.clocks(k);
    @(negedge clk);
  endtask

  task automatic trig(input int d, input int ns);
    if (d == 0) src_in.pulse(ns); else src_out.pulse(ns);
    @(negedge clk);
  endtask

  task automatic lead(input int d, input int k);
    if (d == 0) src_in.lead_clocks(k); else src_out.lead_clocks(k);
    @(negedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  // Control inputs change only at the falling edge of the clock; the source pins mostly switch 3 ns after one.
  initial begin
    for (int d = 0; d < 2; d++) begin
      cfg[d] = mk(1'b0, 1'b1, TRIG_OFF, 1, 0, 0);
      start[d] = 1'b0;
      stop[d] = 1'b0;
    end
    idle(6);
    reset_n = 1'b1;
    @(negedge clk);
    chk("busy at reset", 0, st[1].busy);
    // Internal timer stops by itself at the count.
    go(1, mk(1'b0, 1'b1, TRIG_OFF, 3, 1, 3));
    idle(20);
    chk("count", 3, ev_t[1].size());
    for (int i = 0; i < 3; i++) chk("channel", i % 2, ev_c[1][i]);
    chk("spacing", 3, ev_t[1][2] - ev_t[1][1]);
    chk("busy at count", 0, st[1].busy);
    chk("done with last", ev_t[1][2], done_t[1]);
    // A reset in mid-run returns the direction to idle and silences it.
    go(1, mk(1'b0, 1'b1, TRIG_OFF, 3, 1, 0));
    idle(10);
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    n = ev_t[1].size();
    @(negedge clk);
    chk("busy after reset", 0, st[1].busy);
    idle(10);
    chk("events after reset", n, ev_t[1].size());
    for (int d = 0; d < 2; d++) begin
      // Single shot waits for the trigger, then runs to count or to stop.
      go(d, mk(1'b0, 1'b1, TRIG_SINGLE_SHOT, 5, 0, 4));
      idle(30);
      chk("before trigger", 0, ev_t[d].size());
      t0 = cyc;
      trig(d, 100);
      idle(60);
      chk("count", 4, ev_t[d].size());
      chk("first on trigger", 1, ev_t[d][0] - t0 <= INPUT_HOLD_LATENCY_CYC);
      chk("spacing", 5, ev_t[d][3] - ev_t[d][2]);
      chk("done with last", ev_t[d][3], done_t[d]);
      go(d, mk(1'b0, 1'b1, TRIG_SINGLE_SHOT, 4, 0, 0));
      trig(d, 80);
      idle(40);
      halt(d);
      n = ev_t[d].size();
      idle(20);
      chk("after stop", n, ev_t[d].size());
      // External clock, one channel per edge, first edge counted.
      go(d, mk(1'b1, 1'b0, TRIG_OFF, 1, 2, 0));
      t0 = cyc;
      clocks(d, 5);
      idle(10);
      chk("edges", 5, ev_t[d].size());
      for (int i = 0; i < 5; i++) chk("channel", i % 3, ev_c[d][i]);
      chk("edge latency", 1, ev_t[d][0] - t0 <= (d ? OUTPUT_SLEW_LATENCY_CYC : INPUT_HOLD_LATENCY_CYC));
      halt(d);
      // Whole list per edge; the list takes far less than one clock period.
      go(d, mk(1'b1, 1'b1, TRIG_OFF, 4, 2, 0));
      clocks(d, 2);
      idle(10);
      chk("list events", 6, ev_t[d].size());
      chk("list spacing", 4, ev_t[d][1] - ev_t[d][0]);
      chk("list end", 2, ev_c[d][5]);
      halt(d);
      // Gated: nothing while low, one list for a short pulse, restart on a long one.
      go(d, mk(1'b0, 1'b1, TRIG_GATED, 10, 2, 0));
      idle(20);
      chk("gated low", 0, ev_t[d].size());
      trig(d, 100);
      idle(60);
      chk("short pulse", 3, ev_t[d].size());
      n = ev_t[d].size();
      t0 = cyc;
      trig(d, 600);
      idle(60);
      chk("restart channel", 0, ev_c[d][n]);
      chk("restart on edge", 1, ev_t[d][n] - t0 <= INPUT_HOLD_LATENCY_CYC);
      chk("gated high", 1, ev_t[d].size() > n + 3);
      chk("stop on list end", 2, ev_c[d][ev_t[d].size() - 1]);
      chk("whole lists", 0, ev_t[d].size() % 3);
      halt(d);
      // Gated, one channel per step: a short pulse gives one event, the next pulse resumes the list.
      go(d, mk(1'b0, 1'b0, TRIG_GATED, 40, 2, 0));
      trig(d, 60);
      idle(60);
      trig(d, 60);
      idle(60);
      chk("channel stops", 2, ev_t[d].size());
      chk("channel resumes", 1, ev_c[d][1]);
      halt(d);
      // Trigger ahead of an external clock starts at the next edge.
      go(d, mk(1'b1, 1'b0, TRIG_SINGLE_SHOT, 1, 3, 0));
      clocks(d, 2);
      idle(5);
      chk("clock before trigger", 0, ev_t[d].size());
      lead(d, 3);
      idle(10);
      chk("edges after trigger", 3, ev_t[d].size());
      chk("first channel", 0, ev_c[d][0]);
      halt(d);
    end
    close_out();
  end
endmodule
`default_nettype wire
